// file: common/shid_pkg.sv
/*
  Package for the second-harmonic inrush detector: register map, field layout,
  reset values, setting ranges and the carrier structs.
  Assumes a 32-bit APB bus and a single clk_sys domain.
*/
package shid_pkg;

  localparam int MAG_W = 16;
  localparam int ADDR_W = 8;

  localparam logic [ADDR_W-1:0] OFF_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_RATIO = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_SENS = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h0C;
  localparam logic [ADDR_W-1:0] OFF_IRQ_STAT = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_IRQ_MASK = 8'h14;
  localparam logic [ADDR_W-1:0] OFF_RATED = 8'h18;

  localparam int CTRL_EN_BIT = 0;
  localparam int IRQ_ON_BIT = 0;
  localparam int IRQ_OFF_BIT = 1;
  localparam int IRQ_W = 2;

  localparam logic [6:0] RATIO_MIN = 7'h05;
  localparam logic [6:0] RATIO_MAX = 7'h32;
  localparam logic [6:0] RATIO_RST = 7'h0F;
  localparam logic [6:0] SENS_MIN = 7'h14;
  localparam logic [6:0] SENS_MAX = 7'h64;
  localparam logic [6:0] SENS_RST = 7'h1E;
  localparam logic [MAG_W-1:0] RATED_RST = 16'h1000;
  localparam logic [6:0] PERCENT_FULL = 7'h64;

  typedef struct packed {
    logic [MAG_W-1:0] fund;
    logic [MAG_W-1:0] harm2;
  } shid_phase_t;

  typedef struct packed {
    logic valid;
    shid_phase_t [2:0] ph;
  } shid_sample_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [31:0] pwdata;
  } shid_apb_req_t;

endpackage

// file: hw/shid_phase_cmp.sv
/*
  One phase of the inrush decision, purely combinational.
  Assumes settings are already clamped to their legal ranges.
*/
`timescale 1ns/1ps
module shid_phase_cmp #(
  parameter int MAG_W = 16
) (
  input wire logic [MAG_W-1:0] fund,
  input wire logic [MAG_W-1:0] harm2,
  input wire logic [6:0] ratio_pct,
  input wire logic [MAG_W+6:0] fund_floor,
  output logic detect
);
  logic [MAG_W+6:0] harm_scaled;
  logic [MAG_W+6:0] fund_scaled;
  logic [MAG_W+6:0] fund_wide;

  // Division is avoided: harm2*100 > ratio*fund is the same test as harm2/fund > ratio%.
  always_comb begin
    harm_scaled = (MAG_W + 7)'(harm2) * (MAG_W + 7)'(shid_pkg::PERCENT_FULL);
    fund_scaled = (MAG_W + 7)'(fund) * (MAG_W + 7)'(ratio_pct);
    fund_wide = (MAG_W + 7)'(fund) * (MAG_W + 7)'(shid_pkg::PERCENT_FULL);
    detect = (harm_scaled > fund_scaled) && (fund_wide > fund_floor);
  end
endmodule

// file: hw/shid_top.sv
/*
  Second-harmonic inrush detector with an APB register file and one interrupt.
  Assumes magnitudes arrive synchronous to clk_sys with a one-cycle valid strobe.
*/
`timescale 1ns/1ps
// Summary of operation
// - Flag when harmonic ratio exceeds threshold
// - Ratio threshold 5 to 50 percent, reset 15
// - No flag unless fundamental above sensitivity
// - Sensitivity 20 to 100 percent, reset 30
// - Each phase evaluated independently
// - General flag is OR of phases
// - Blocking input clears phase and general flags
// - On and off events follow general flag
module shid_top #(
  parameter int MAG_W = shid_pkg::MAG_W
) (
  input wire logic clk_sys,
  input wire logic srst,
  input wire shid_pkg::shid_sample_t sample_in,
  input wire logic inrush_block_in,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [shid_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic inrush_phase1_out,
  output logic inrush_phase2_out,
  output logic inrush_phase3_out,
  output logic inrush_any_phase_out,
  output logic harmonic_restraint_event,
  output logic irq
);

  logic enable_ff, nxt_enable;
  logic [6:0] harmonic_ratio_threshold_ff, nxt_ratio;
  logic [6:0] fundamental_min_level_ff, nxt_sens;
  logic [MAG_W-1:0] rated_ff, nxt_rated;
  logic [shid_pkg::IRQ_W-1:0] irq_stat_ff, nxt_irq_stat;
  logic [shid_pkg::IRQ_W-1:0] irq_mask_ff, nxt_irq_mask;
  logic [31:0] prdata_ff, nxt_prdata;
  logic pready_ff, nxt_pready;
  logic pslverr_ff, nxt_pslverr;
  logic [2:0] phase_ff, nxt_phase;
  logic any_ff, nxt_any;
  logic event_ff, nxt_event;
  logic irq_ff, nxt_irq;
  logic [2:0] det;
  logic [MAG_W+6:0] fund_floor;
  logic access;
  logic [6:0] wr7;
  logic [shid_pkg::IRQ_W-1:0] irq_clr;

  // The answer is registered, so every access costs one wait state; in return
  // the read mux stays off the bus output path.
  assign access = psel && penable && !pready_ff;
  assign wr7 = pwdata[6:0];
  // Threshold in magnitude units times 100, shared by all phases.
  assign fund_floor = (MAG_W + 7)'(rated_ff) * (MAG_W + 7)'(fundamental_min_level_ff);

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_phase
      shid_phase_cmp #(
        .MAG_W(MAG_W)
      ) u_cmp (
        .fund(sample_in.ph[gi].fund),
        .harm2(sample_in.ph[gi].harm2),
        .ratio_pct(harmonic_ratio_threshold_ff),
        .fund_floor(fund_floor),
        .detect(det[gi])
      );
    end
  endgenerate

  // Register file. Out-of-range settings are clamped rather than refused so a
  // write always leaves a legal value behind.
  always_comb begin
    nxt_enable = enable_ff;
    nxt_ratio = harmonic_ratio_threshold_ff;
    nxt_sens = fundamental_min_level_ff;
    nxt_rated = rated_ff;
    nxt_irq_mask = irq_mask_ff;
    irq_clr = '0;
    if (access && pwrite) begin
      if (paddr == shid_pkg::OFF_CTRL) begin
        nxt_enable = pwdata[shid_pkg::CTRL_EN_BIT];
      end else if (paddr == shid_pkg::OFF_RATIO) begin
        if (wr7 < shid_pkg::RATIO_MIN || pwdata[31:7] != 25'h0) begin
          nxt_ratio = (pwdata[31:7] != 25'h0) ? shid_pkg::RATIO_MAX : shid_pkg::RATIO_MIN;
        end else if (wr7 > shid_pkg::RATIO_MAX) begin
          nxt_ratio = shid_pkg::RATIO_MAX;
        end else begin
          nxt_ratio = wr7;
        end
      end else if (paddr == shid_pkg::OFF_SENS) begin
        if (wr7 < shid_pkg::SENS_MIN && pwdata[31:7] == 25'h0) begin
          nxt_sens = shid_pkg::SENS_MIN;
        end else if (wr7 > shid_pkg::SENS_MAX || pwdata[31:7] != 25'h0) begin
          nxt_sens = shid_pkg::SENS_MAX;
        end else begin
          nxt_sens = wr7;
        end
      end else if (paddr == shid_pkg::OFF_IRQ_STAT) begin
        irq_clr = pwdata[shid_pkg::IRQ_W-1:0];
      end else if (paddr == shid_pkg::OFF_IRQ_MASK) begin
        nxt_irq_mask = pwdata[shid_pkg::IRQ_W-1:0];
      end else if (paddr == shid_pkg::OFF_RATED) begin
        nxt_rated = pwdata[MAG_W-1:0];
      end
    end
  end

  // Bus response. The address is decoded for every access, so an unmapped
  // address reports an error in both directions.
  always_comb begin
    nxt_prdata = 32'h0;
    nxt_pready = access;
    nxt_pslverr = 1'b0;
    if (access) begin
      if (paddr == shid_pkg::OFF_CTRL) begin
        nxt_prdata = {31'h0, enable_ff};
      end else if (paddr == shid_pkg::OFF_RATIO) begin
        nxt_prdata = {25'h0, harmonic_ratio_threshold_ff};
      end else if (paddr == shid_pkg::OFF_SENS) begin
        nxt_prdata = {25'h0, fundamental_min_level_ff};
      end else if (paddr == shid_pkg::OFF_STATUS) begin
        nxt_prdata = {28'h0, any_ff, phase_ff};
      end else if (paddr == shid_pkg::OFF_IRQ_STAT) begin
        nxt_prdata = {30'h0, irq_stat_ff};
      end else if (paddr == shid_pkg::OFF_IRQ_MASK) begin
        nxt_prdata = {30'h0, irq_mask_ff};
      end else if (paddr == shid_pkg::OFF_RATED) begin
        nxt_prdata = {16'h0, rated_ff};
      end else begin
        nxt_pslverr = 1'b1;
      end
      // Writes return zero data; a write to the read-only status word is harmless.
      if (pwrite) begin
        nxt_prdata = 32'h0;
      end
    end
  end

  // Sticky interrupt causes. A new edge of the general flag wins over a
  // write-one-to-clear in the same cycle, so no edge is ever lost.
  always_comb begin
    nxt_irq_stat = irq_stat_ff & ~irq_clr;
    if (nxt_any && !any_ff) begin
      nxt_irq_stat[shid_pkg::IRQ_ON_BIT] = 1'b1;
    end
    if (!nxt_any && any_ff) begin
      nxt_irq_stat[shid_pkg::IRQ_OFF_BIT] = 1'b1;
    end
    nxt_irq = |(nxt_irq_stat & nxt_irq_mask);
  end

  // Detection path: phase and general flags change only on a valid sample, except that blocking
  // or disabling clears them at once.
  always_comb begin
    nxt_phase = phase_ff;
    if (!enable_ff || inrush_block_in) begin
      nxt_phase = 3'h0;
    end else if (sample_in.valid) begin
      nxt_phase = det;
    end
    nxt_any = |nxt_phase;
    nxt_event = nxt_any != any_ff;
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      enable_ff <= 1'b0;
      harmonic_ratio_threshold_ff <= shid_pkg::RATIO_RST;
      fundamental_min_level_ff <= shid_pkg::SENS_RST;
      rated_ff <= shid_pkg::RATED_RST;
      irq_mask_ff <= 2'h0;
    end else begin
      enable_ff <= nxt_enable;
      harmonic_ratio_threshold_ff <= nxt_ratio;
      fundamental_min_level_ff <= nxt_sens;
      rated_ff <= nxt_rated;
      irq_mask_ff <= nxt_irq_mask;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      prdata_ff <= 32'h0;
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
    end else begin
      prdata_ff <= nxt_prdata;
      pready_ff <= nxt_pready;
      pslverr_ff <= nxt_pslverr;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      irq_stat_ff <= 2'h0;
      irq_ff <= 1'b0;
    end else begin
      irq_stat_ff <= nxt_irq_stat;
      irq_ff <= nxt_irq;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      phase_ff <= 3'h0;
      any_ff <= 1'b0;
      event_ff <= 1'b0;
    end else begin
      phase_ff <= nxt_phase;
      any_ff <= nxt_any;
      event_ff <= nxt_event;
    end
  end

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign inrush_phase1_out = phase_ff[0];
  assign inrush_phase2_out = phase_ff[1];
  assign inrush_phase3_out = phase_ff[2];
  assign inrush_any_phase_out = any_ff;
  assign harmonic_restraint_event = event_ff;
  assign irq = irq_ff;

  // Settings, register bus and detection path flags.
  reset_values_a: assert property (@(posedge clk_sys) disable iff (srst)
    $past(srst) |-> !enable_ff && harmonic_ratio_threshold_ff == shid_pkg::RATIO_RST
      && fundamental_min_level_ff == shid_pkg::SENS_RST)
    else $error("settings not at reset values");
  enable_write_a: assert property (@(posedge clk_sys) disable iff (srst)
    (access && pwrite && paddr == shid_pkg::OFF_CTRL)
      |=> enable_ff == $past(pwdata[shid_pkg::CTRL_EN_BIT]))
    else $error("enable write lost");
  mask_write_a: assert property (@(posedge clk_sys) disable iff (srst)
    (access && pwrite && paddr == shid_pkg::OFF_IRQ_MASK)
      |=> irq_mask_ff == $past(pwdata[shid_pkg::IRQ_W-1:0]))
    else $error("mask write lost");
  rated_write_a: assert property (@(posedge clk_sys) disable iff (srst)
    (access && pwrite && paddr == shid_pkg::OFF_RATED)
      |=> rated_ff == $past(pwdata[MAG_W-1:0]))
    else $error("rated current write lost");
  write_data_zero_a: assert property (@(posedge clk_sys) disable iff (srst)
    (access && pwrite) |=> prdata == 32'h0)
    else $error("read data driven on a write");
  status_read_a: assert property (@(posedge clk_sys) disable iff (srst)
    (access && !pwrite && paddr == shid_pkg::OFF_STATUS)
      |=> prdata == {28'h0, $past(inrush_any_phase_out), $past(phase_ff)})
    else $error("status word differs from flags");
  ready_pulse_a: assert property (@(posedge clk_sys) disable iff (srst)
    pready |=> !pready)
    else $error("pready longer than one cycle");
  err_with_ready_a: assert property (@(posedge clk_sys) disable iff (srst)
    pslverr |-> pready)
    else $error("pslverr without pready");
  ratio_range_a: assert property (@(posedge clk_sys) disable iff (srst)
    harmonic_ratio_threshold_ff >= 7'h05 && harmonic_ratio_threshold_ff <= 7'h32)
    else $error("ratio setting out of range");
  sens_range_a: assert property (@(posedge clk_sys) disable iff (srst)
    fundamental_min_level_ff >= 7'h14 && fundamental_min_level_ff <= 7'h64)
    else $error("sensitivity setting out of range");
  block_clears_a: assert property (@(posedge clk_sys) disable iff (srst)
    inrush_block_in |=> !inrush_any_phase_out && phase_ff == 3'h0)
    else $error("outputs not cleared by block");
  disable_clears_a: assert property (@(posedge clk_sys) disable iff (srst)
    !enable_ff |=> phase_ff == 3'h0 && !$rose(inrush_any_phase_out))
    else $error("outputs active while disabled");
  general_or_a: assert property (@(posedge clk_sys) disable iff (srst)
    inrush_any_phase_out == |phase_ff)
    else $error("general flag differs from phase OR");
  event_edge_a: assert property (@(posedge clk_sys) disable iff (srst)
    harmonic_restraint_event == $changed(inrush_any_phase_out))
    else $error("event does not follow general flag edge");
  sample_hold_a: assert property (@(posedge clk_sys) disable iff (srst)
    (!sample_in.valid && enable_ff && !inrush_block_in) |=> $stable(phase_ff))
    else $error("flags moved without a sample");
  phase_detect_a: assert property (@(posedge clk_sys) disable iff (srst)
    (sample_in.valid && enable_ff && !inrush_block_in) |=> phase_ff == $past(det))
    else $error("phase flags differ from comparison");
  low_fund_a: assert property (@(posedge clk_sys) disable iff (srst)
    (sample_in.valid && sample_in.ph[0].fund == '0) |=> !inrush_phase1_out)
    else $error("flag with zero fundamental");
  apb_answer_a: assert property (@(posedge clk_sys) disable iff (srst)
    (psel && penable && !pready) |=> pready)
    else $error("apb access not answered in one cycle");

  // Detection path and interrupt causes.
  low_fund2_a: assert property (@(posedge clk_sys) disable iff (srst)
    (sample_in.valid && sample_in.ph[1].fund == '0) |=> !inrush_phase2_out)
    else $error("phase two flag with zero fundamental");
  low_fund3_a: assert property (@(posedge clk_sys) disable iff (srst)
    (sample_in.valid && sample_in.ph[2].fund == '0) |=> !inrush_phase3_out)
    else $error("phase three flag with zero fundamental");
  rise_cause_a: assert property (@(posedge clk_sys) disable iff (srst)
    $rose(inrush_any_phase_out) |-> irq_stat_ff[shid_pkg::IRQ_ON_BIT])
    else $error("rise of general flag not recorded");
  fall_cause_a: assert property (@(posedge clk_sys) disable iff (srst)
    $fell(inrush_any_phase_out) |-> irq_stat_ff[shid_pkg::IRQ_OFF_BIT])
    else $error("fall of general flag not recorded");
  irq_level_a: assert property (@(posedge clk_sys) disable iff (srst)
    irq == |(irq_stat_ff & irq_mask_ff))
    else $error("interrupt differs from masked causes");
endmodule

// file: bench/shid_src_model.sv
/*
  Upstream magnitude source model for the inrush bench.
  Assumes the bench requests one sample at a time on clk_sys.
*/
`timescale 1ns/1ps
module shid_src_model (
  input wire logic clk_sys,
  input wire logic req,
  input wire shid_pkg::shid_phase_t [2:0] ph,
  output shid_pkg::shid_sample_t smp
);
  shid_pkg::shid_sample_t smp_q = '0;
  // Outside a valid strobe the magnitudes toggle, so a design leaning on stale data is caught.
  always @(posedge clk_sys) begin
    smp_q.valid <= req;
    smp_q.ph <= req ? ph : ~smp_q.ph;
  end
  assign smp = smp_q;
endmodule

// file: bench/second_harmonic_inrush_detector_tb_top.sv
/*
  Self-checking bench for the inrush detector top.
  Assumes the source model feeds samples and APB reaches the registers.
*/
`timescale 1ns/1ps
module second_harmonic_inrush_detector_tb_top;
  logic clk_sys = 0;
  logic srst = 1;
  logic req = 0;
  logic blk = 0;
  logic psel = 0;
  logic penable = 0;
  logic pwrite = 0;
  logic [7:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic pready, pslverr, irq, ev, e;
  wire [3:0] fl;
  logic [3:0] ex;
  logic [1:0] stat = '0;
  logic [1:0] mask = '0;
  logic pany = 0;
  shid_pkg::shid_phase_t [2:0] ph = '0;
  shid_pkg::shid_sample_t smp;
  int err_total = 0;
  int checked = 0;
  int ratio = 15;
  int sens = 30;
  int rw[4] = '{5, 50, 4, 51};
  int sw[4] = '{20, 100, 19, 101};

  always #12.5 clk_sys = ~clk_sys;

  shid_src_model i_src (.clk_sys(clk_sys), .req(req), .ph(ph), .smp(smp));

  shid_top i_dut (
    .clk_sys(clk_sys), .srst(srst), .sample_in(smp), .inrush_block_in(blk),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .inrush_phase1_out(fl[0]), .inrush_phase2_out(fl[1]), .inrush_phase3_out(fl[2]),
    .inrush_any_phase_out(fl[3]), .harmonic_restraint_event(ev), .irq(irq)
  );

  function automatic logic det(input int f, input int h);
    return h * 100 > ratio * f && f * 100 > int'(shid_pkg::RATED_RST) * sens;
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      err_total++;
      $display("ERROR %0t no pready for address %h", $time, a);
    end
    rd = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Let the released bus be seen for one edge before the next setup.
    @(posedge clk_sys);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk(rd, x);
    chk(e, 1'b0);
  endtask

  task automatic send(input shid_pkg::shid_phase_t [2:0] p, input logic en);
    for (int i = 0; i < 3; i++)
      ex[i] = en && det(p[i].fund, p[i].harm2);
    ex[3] = |ex[2:0];
    ph <= p;
    req <= 1'b1;
    @(posedge clk_sys);
    req <= 1'b0;
    @(posedge clk_sys);
    // Flags, the one-cycle event and the interrupt all stand from this edge on.
    #1;
    chk(fl, ex);
    chk(ev, ex[3] != pany);
    stat[0] = stat[0] | (ex[3] & ~pany);
    stat[1] = stat[1] | (~ex[3] & pany);
    pany = ex[3];
    chk(irq, |(stat & mask));
    @(posedge clk_sys);
  endtask

  task automatic rsend(input logic en);
    shid_pkg::shid_phase_t [2:0] p;
    for (int i = 0; i < 3; i++) begin
      p[i].fund = 16'($urandom_range(3000, 600));
      p[i].harm2 = 16'(p[i].fund * $urandom_range(60) / 100);
    end
    send(p, en);
  endtask

  task automatic report_and_stop();
    $display("checks %0d errors %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  initial begin
    #100us;
    err_total++;
    report_and_stop();
  end

  initial begin
    void'($urandom(11));
    repeat (5) @(posedge clk_sys);
    srst <= 1'b0;
    @(posedge clk_sys);
    rdc(shid_pkg::OFF_RATIO, 32'h0F);
    rdc(shid_pkg::OFF_SENS, 32'h1E);
    rdc(shid_pkg::OFF_CTRL, 32'h0);
    rdc(shid_pkg::OFF_RATED, {16'h0, shid_pkg::RATED_RST});
    apb(1'b1, shid_pkg::OFF_STATUS, 32'hF);
    chk(e, 1'b0);
    apb(1'b0, 8'h1C, 32'h0);
    chk(e, 1'b1);
    apb(1'b1, shid_pkg::OFF_IRQ_MASK, 32'h3);
    mask = 2'h3;
    rdc(shid_pkg::OFF_IRQ_MASK, 32'h3);
    repeat (3) rsend(1'b0);
    apb(1'b1, shid_pkg::OFF_CTRL, 32'h1);
    // Exact ratio boundary (equal products must not detect) and the sensitivity step from fundamental 1228 to 1229.
    send('{'{16'h04CC, 16'h03E8}, '{16'h07D0, 16'h012D}, '{16'h07D0, 16'h012C}}, 1'b1);
    send('{'{16'h04CD, 16'h03E8}, '{16'h07D0, 16'h012C}, '{16'h07D0, 16'h012D}}, 1'b1);
    rdc(shid_pkg::OFF_STATUS, {28'h0, ex});
    repeat (40) rsend(1'b1);
    send('0, 1'b1);
    blk <= 1'b1;
    repeat (5) rsend(1'b0);
    blk <= 1'b0;
    rdc(shid_pkg::OFF_IRQ_STAT, {30'h0, stat});
    apb(1'b1, shid_pkg::OFF_IRQ_STAT, 32'h3);
    stat = '0;
    rdc(shid_pkg::OFF_IRQ_STAT, 32'h0);
    chk(irq, 1'b0);
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, shid_pkg::OFF_RATIO, 32'(rw[i]));
      rdc(shid_pkg::OFF_RATIO, (i == 2) ? 32'h5 : 32'(rw[i] > 50 ? 50 : rw[i]));
      apb(1'b1, shid_pkg::OFF_SENS, 32'(sw[i]));
      rdc(shid_pkg::OFF_SENS, (i == 2) ? 32'h14 : 32'(sw[i] > 100 ? 100 : sw[i]));
    end
    apb(1'b1, shid_pkg::OFF_SENS, 32'h14);
    ratio = 50;
    sens = 20;
    repeat (15) rsend(1'b1);
    send('0, 1'b1);
    apb(1'b1, shid_pkg::OFF_CTRL, 32'h0);
    repeat (3) rsend(1'b0);
    report_and_stop();
  end
endmodule
